// file: design/cdam_core.sv
// Instruction decoder, addressing modes and mask bits of the 8-bit core
`timescale 1ns/100ps
`include "cdam_defines.svh"

module cdam_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic maskable_request,
	input wire logic nonmaskable_pin_request,
	output logic stopped
);
	import cdam_pkg::*;

	cdam_state_t state_q, state_d; // Sequencer state
	cdam_mode_t mode_q, dec_mode; // Addressing mode
	cdam_op_t op_q, dec_op; // Operation class
	logic [3:0] cnt_q; // Cycles spent in this instruction
	logic [3:0] tot_q, dec_tot; // Fixed cycle count
	logic [3:0] step_q; // Stack byte step
	logic [1:0] page_q, pre_page; // Opcode page
	logic [1:0] left_q, dec_nopd; // Operand bytes still to come
	logic accb_q, dec_accb; // Target is second accumulator
	logic idxy_q, dec_idxy; // Second index register selected
	logic [7:0] opc_q; // Latched opcode byte
	logic [7:0] hi_q; // High address byte being built
	logic [7:0] rel_q; // Branch offset
	logic [15:0] ea_q, ea_now; // Effective address
	logic [15:0] vec_q; // Vector to fetch
	logic [15:0] pc_q, pc_d; // instruction_pointer: next byte to fetch
	logic [15:0] sp_q, sp_d; // Stack pointer
	logic [15:0] pc_nxt; // Address of next instruction
	logic [7:0] acc_a_q, acc_b_q; // Accumulators
	logic [15:0] first_index_reg_q, second_index_reg_q;
	logic [7:0] flag_register_q; // S X H I N Z V C
	logic [2:0] ctrl_q; // Run and soft request bits
	logic [15:0] addr_d;
	logic rd_d, wr_d;
	logic [7:0] wdata_d;
	logic is_pre, fin, nxt_last, mem_mode, taken;
	logic pend_pin, pend_mask, pend_any;
	logic [7:0] alu_a, alu_b, alu_sum;
	logic alu_h, alu_n, alu_z, alu_v, alu_c;

	////////////////////////////////////////////////////////////////////////
	// Stack frame byte by push order; lowest step sits highest in memory
	function automatic logic [7:0] frame_byte(input logic [3:0] k);
		case (k)
			// Pointer already holds the return address while stacking runs
			4'd0: frame_byte = pc_q[7:0];
			4'd1: frame_byte = pc_q[15:8];
			4'd2: frame_byte = second_index_reg_q[7:0];
			4'd3: frame_byte = second_index_reg_q[15:8];
			4'd4: frame_byte = first_index_reg_q[7:0];
			4'd5: frame_byte = first_index_reg_q[15:8];
			4'd6: frame_byte = acc_a_q;
			4'd7: frame_byte = acc_b_q;
			default: frame_byte = flag_register_q;
		endcase
	endfunction : frame_byte

	// Branch condition: pairs of opcodes, odd one inverted
	function automatic logic branch_ok(input logic [3:0] cc,
			input logic [7:0] f);
		logic r;
		r = 1'b1;
		case (cc[3:1])
			3'd0: r = 1'b1;
			3'd1: r = ~(f[`CDAM_FLAG_C] | f[`CDAM_FLAG_Z]);
			3'd2: r = ~f[`CDAM_FLAG_C];
			3'd3: r = ~f[`CDAM_FLAG_Z];
			3'd4: r = ~f[`CDAM_FLAG_V];
			3'd5: r = ~f[`CDAM_FLAG_N];
			3'd6: r = ~(f[`CDAM_FLAG_N] ^ f[`CDAM_FLAG_V]);
			default: r = ~(f[`CDAM_FLAG_Z] |
				(f[`CDAM_FLAG_N] ^ f[`CDAM_FLAG_V]));
		endcase
		branch_ok = r ^ cc[0];
	endfunction : branch_ok

	////////////////////////////////////////////////////////////////////////
	// Opcode decode of the byte now on the bus
	always_comb begin
		is_pre = (page_q == 2'd0) && ((mem_rdata == `CDAM_PRE_PAGE1) ||
			(mem_rdata == `CDAM_PRE_PAGE2) || (mem_rdata == `CDAM_PRE_PAGE3));
		pre_page = (mem_rdata == `CDAM_PRE_PAGE1) ? 2'd1 :
			(mem_rdata == `CDAM_PRE_PAGE2) ? 2'd2 : 2'd3;
		dec_op = OP_NOP;
		dec_mode = MD_INH;
		dec_tot = `CDAM_CYC_INH;
		dec_accb = mem_rdata[6];
		dec_idxy = (page_q == 2'd1);
		if (mem_rdata[7] && (page_q == 2'd0 ||
				(page_q == 2'd1 && mem_rdata[5:4] == 2'b10)) &&
				(mem_rdata[3:0] == `CDAM_COL_ADD_CARRY ||
				mem_rdata[3:0] == `CDAM_COL_ADD_MEM)) begin
			dec_op = (mem_rdata[3:0] == `CDAM_COL_ADD_CARRY) ? OP_ADC : OP_ADD;
			case (mem_rdata[5:4])
				2'b00: begin dec_mode = MD_IMM; dec_tot = `CDAM_CYC_IMM; end
				2'b01: begin dec_mode = MD_DIR; dec_tot = `CDAM_CYC_DIR; end
				2'b10: begin dec_mode = MD_IND; dec_tot = `CDAM_CYC_IND; end
				default: begin dec_mode = MD_EXT; dec_tot = `CDAM_CYC_EXT; end
			endcase
		end else if (mem_rdata == `CDAM_OP_ADD_ACC_IDX &&
				page_q <= 2'd1) begin
			dec_op = OP_ADD_IDX;
			dec_tot = `CDAM_CYC_ADD_IDX;
		end else if (page_q == 2'd0) begin
			case (mem_rdata)
				`CDAM_OP_ADD_ACCS: dec_op = OP_ADD_ACCS;
				`CDAM_OP_ACC_TO_FLAGS: dec_op = OP_TAP;
				`CDAM_OP_INT_RETURN: dec_op = OP_INT_RET;
				`CDAM_OP_HALT: dec_op = OP_STOP;
				default: begin
					if (mem_rdata[7:4] == 4'h2) begin
						dec_op = OP_BR;
						dec_mode = MD_REL;
						dec_tot = `CDAM_CYC_REL;
					end
				end
			endcase
		end
		if (page_q != 2'd0) begin
			dec_tot = dec_tot + 4'd1;
		end
		// zero to two operand bytes here
		case (dec_mode)
			MD_INH: dec_nopd = 2'd0;
			MD_EXT: dec_nopd = 2'd2;
			default: dec_nopd = 2'd1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Addressing, branch target and interrupt pending terms
	always_comb begin
		case (mode_q)
			MD_DIR: ea_now = {8'h00, mem_rdata};
			MD_EXT: ea_now = {hi_q, mem_rdata};
			MD_IND: ea_now = (idxy_q ? second_index_reg_q : first_index_reg_q)
				+ {8'h00, mem_rdata};
			default: ea_now = pc_q;
		endcase
		mem_mode = (mode_q == MD_DIR) || (mode_q == MD_EXT) ||
			(mode_q == MD_IND);
		nxt_last = ((cnt_q + 4'd1) == (tot_q - 4'd1));
		fin = (cnt_q == (tot_q - 4'd1)) &&
			((state_q == ST_OPD) || (state_q == ST_LAST));
		taken = (op_q == OP_BR) && branch_ok(opc_q[3:0], flag_register_q);
		pc_nxt = taken ? pc_q + {{8{rel_q[7]}}, rel_q} : pc_q;
		pend_pin = (nonmaskable_pin_request | ctrl_q[`CDAM_CTRL_SOFT_PIN]) &
			~flag_register_q[`CDAM_FLAG_X];
		pend_mask = (maskable_request | ctrl_q[`CDAM_CTRL_SOFT_MASKABLE]) &
			~flag_register_q[`CDAM_FLAG_I];
		pend_any = pend_pin | pend_mask;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state and next bus cycle; one bus access per cycle
	always_comb begin
		state_d = state_q;
		addr_d = mem_addr;
		rd_d = 1'b0;
		wr_d = 1'b0;
		wdata_d = 8'h00;
		pc_d = pc_q;
		sp_d = sp_q;
		case (state_q)
			ST_IDLE: begin
				if (ctrl_q[`CDAM_CTRL_RUN]) begin
					state_d = ST_VEC0;
				end
			end
			ST_VEC0: begin
				addr_d = vec_q;
				rd_d = 1'b1;
				state_d = ST_VHI;
			end
			ST_VHI: begin
				addr_d = vec_q + 16'h0001;
				rd_d = 1'b1;
				state_d = ST_VLO;
			end
			ST_VLO, ST_PULL: begin
				rd_d = 1'b1;
				if (state_q == ST_VLO || step_q == `CDAM_STACK_BYTES) begin
					addr_d = {hi_q, mem_rdata};
					pc_d = {hi_q, mem_rdata} + 16'h0001;
					state_d = ST_OPC;
				end else begin
					addr_d = sp_q + 16'h0001;
					sp_d = sp_q + 16'h0001;
				end
			end
			ST_OPC: begin
				rd_d = 1'b1;
				addr_d = pc_q;
				if (is_pre || dec_nopd != 2'd0) begin
					pc_d = pc_q + 16'h0001;
				end
				if (!is_pre && dec_nopd != 2'd0) begin
					state_d = ST_OPD;
				end else if (!is_pre) begin
					state_d = ((cnt_q + 4'd1) == (dec_tot - 4'd1)) ?
						ST_LAST : ST_WAIT;
				end
			end
			ST_OPD: begin
				rd_d = 1'b1;
				if (left_q == 2'd2) begin
					addr_d = pc_q;
					pc_d = pc_q + 16'h0001;
				end else begin
					state_d = nxt_last ? ST_LAST : ST_WAIT;
					addr_d = (nxt_last && mem_mode) ? ea_now : pc_q;
				end
			end
			ST_WAIT: begin
				rd_d = 1'b1;
				state_d = nxt_last ? ST_LAST : ST_WAIT;
				addr_d = (nxt_last && mem_mode) ? ea_q : pc_q;
			end
			ST_PUSH: begin
				// low byte pushed first, ends higher
				wr_d = 1'b1;
				addr_d = sp_q;
				wdata_d = frame_byte(step_q);
				sp_d = sp_q - 16'h0001;
				if (step_q == (`CDAM_STACK_BYTES - 4'd1)) begin
					state_d = ST_VEC0;
				end
			end
			ST_STOP: begin
				if (maskable_request | nonmaskable_pin_request |
						ctrl_q[`CDAM_CTRL_SOFT_MASKABLE] |
						ctrl_q[`CDAM_CTRL_SOFT_PIN]) begin
					addr_d = pc_q;
					rd_d = 1'b1;
					pc_d = pc_q + 16'h0001;
					state_d = ST_OPC;
				end
			end
			default: ;
		endcase
		// Instruction boundary
		if (fin) begin
			if (op_q == OP_STOP && !flag_register_q[`CDAM_FLAG_S]) begin
				state_d = ST_STOP;
			end else if (op_q == OP_INT_RET) begin
				addr_d = sp_q + 16'h0001;
				rd_d = 1'b1;
				sp_d = sp_q + 16'h0001;
				state_d = ST_PULL;
			end else if (pend_any) begin
				pc_d = pc_nxt;
				addr_d = sp_q;
				wr_d = 1'b1;
				wdata_d = pc_nxt[7:0];
				sp_d = sp_q - 16'h0001;
				state_d = ST_PUSH;
			end else begin
				addr_d = pc_nxt;
				rd_d = 1'b1;
				pc_d = pc_nxt + 16'h0001;
				state_d = ST_OPC;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer registers and decode latches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'd0;
			step_q <= 4'd0;
			page_q <= 2'd0;
			left_q <= 2'd0;
			op_q <= OP_NOP;
			mode_q <= MD_INH;
			tot_q <= `CDAM_CYC_INH;
			accb_q <= 1'b0;
			idxy_q <= 1'b0;
			opc_q <= 8'h00;
			hi_q <= 8'h00;
			rel_q <= 8'h00;
			ea_q <= 16'h0000;
			vec_q <= `CDAM_VEC_RESET;
		end else begin
			state_q <= state_d;
			if (fin || !(state_q == ST_OPC || state_q == ST_OPD ||
					state_q == ST_WAIT)) begin
				cnt_q <= 4'd0;
			end else begin
				cnt_q <= cnt_q + 4'd1;
			end
			if (state_q == ST_OPC) begin
				page_q <= is_pre ? pre_page : 2'd0;
				if (!is_pre) begin
					op_q <= dec_op;
					mode_q <= dec_mode;
					tot_q <= dec_tot;
					accb_q <= dec_accb;
					idxy_q <= dec_idxy;
					opc_q <= mem_rdata;
					left_q <= dec_nopd;
				end
			end
			if (state_q == ST_OPD) begin
				left_q <= left_q - 2'd1;
				rel_q <= mem_rdata;
				ea_q <= ea_now;
				if (left_q == 2'd2) begin
					hi_q <= mem_rdata;
				end
			end
			// Vector high byte, or return pointer high byte
			if (state_q == ST_VHI ||
					(state_q == ST_PULL && step_q == 4'd8)) begin
				hi_q <= mem_rdata;
			end
			if (fin) begin
				step_q <= 4'd1;
			end else if (state_q == ST_PUSH || state_q == ST_PULL) begin
				step_q <= step_q + 4'd1;
			end
			// A halt that runs as a no-op still takes its vector
			if (fin && pend_any && op_q != OP_INT_RET &&
					(op_q != OP_STOP || flag_register_q[`CDAM_FLAG_S])) begin
				vec_q <= pend_pin ? `CDAM_VEC_PIN : `CDAM_VEC_MASKABLE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= 16'h0000;
			sp_q <= `CDAM_SP_RESET;
		end else begin
			pc_q <= pc_d;
			sp_q <= sp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Adder shared by the add group
	always_comb begin
		alu_a = accb_q ? acc_b_q : acc_a_q;
		alu_b = (op_q == OP_ADD_ACCS) ? acc_b_q : mem_rdata;
		if (op_q == OP_ADD_ACCS) begin
			alu_a = acc_a_q;
		end
	end

	cdam_alu8 u_alu (
		.a(alu_a),
		.b(alu_b),
		.cin((op_q == OP_ADC) & flag_register_q[`CDAM_FLAG_C]),
		.sum(alu_sum),
		.half(alu_h),
		.neg(alu_n),
		.zero(alu_z),
		.ovf(alu_v),
		.carry(alu_c)
	);

	////////////////////////////////////////////////////////////////////////
	// Accumulators and index registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_a_q <= 8'h00;
			acc_b_q <= 8'h00;
			first_index_reg_q <= 16'h0000;
			second_index_reg_q <= 16'h0000;
		end else if (fin && (op_q == OP_ADD_ACCS || op_q == OP_ADC ||
				op_q == OP_ADD)) begin
			if (accb_q && op_q != OP_ADD_ACCS) begin
				acc_b_q <= alu_sum;
			end else begin
				acc_a_q <= alu_sum;
			end
		end else if (fin && op_q == OP_ADD_IDX) begin
			if (idxy_q) begin
				second_index_reg_q <= second_index_reg_q + {8'h00, acc_b_q};
			end else begin
				first_index_reg_q <= first_index_reg_q + {8'h00, acc_b_q};
			end
		end else if (state_q == ST_PULL) begin
			case (step_q)
				4'd2: acc_b_q <= mem_rdata;
				4'd3: acc_a_q <= mem_rdata;
				4'd4: first_index_reg_q[15:8] <= mem_rdata;
				4'd5: first_index_reg_q[7:0] <= mem_rdata;
				4'd6: second_index_reg_q[15:8] <= mem_rdata;
				4'd7: second_index_reg_q[7:0] <= mem_rdata;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flag register; the pin mask has no hardware clear path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_register_q <= `CDAM_FLAGS_RESET;
		end else if (state_q == ST_VEC0) begin
			flag_register_q[`CDAM_FLAG_X] <= 1'b1;
			flag_register_q[`CDAM_FLAG_I] <= 1'b1;
		end else if (fin && (op_q == OP_ADD_ACCS || op_q == OP_ADC ||
				op_q == OP_ADD)) begin
			flag_register_q[`CDAM_FLAG_H] <= alu_h;
			flag_register_q[`CDAM_FLAG_N] <= alu_n;
			flag_register_q[`CDAM_FLAG_Z] <= alu_z;
			flag_register_q[`CDAM_FLAG_V] <= alu_v;
			flag_register_q[`CDAM_FLAG_C] <= alu_c;
		end else if (fin && op_q == OP_TAP) begin
			flag_register_q <= {acc_a_q[7],
				acc_a_q[6] & flag_register_q[`CDAM_FLAG_X], acc_a_q[5:0]};
		end else if (state_q == ST_PULL && step_q == 4'd1) begin
			// restored bit 6 may only clear
			flag_register_q <= {mem_rdata[7],
				mem_rdata[6] & flag_register_q[`CDAM_FLAG_X], mem_rdata[5:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory bus outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_addr <= 16'h0000;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
			stopped <= 1'b0;
		end else begin
			mem_addr <= addr_d;
			mem_rd <= rd_d;
			mem_wr <= wr_d;
			mem_wdata <= wdata_d;
			stopped <= (state_d == ST_STOP);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states; answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			ctrl_q <= `CDAM_CTRL_RESET;
		end else begin
			pready <= psel & ~penable;
			// Error flag stands only in the access cycle, beside pready
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
					`CDAM_REG_CTRL: prdata <= {29'h0, ctrl_q};
					`CDAM_REG_STATUS: prdata <= {22'h0,
						(state_q != ST_IDLE), (state_q == ST_STOP),
						flag_register_q};
					`CDAM_REG_ACC: prdata <= {16'h0000, acc_a_q, acc_b_q};
					`CDAM_REG_INDEX: prdata <= {second_index_reg_q,
						first_index_reg_q};
					`CDAM_REG_PTRS: prdata <= {sp_q, pc_q};
					default: begin
						// Unmapped offset answers with an error
						prdata <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end
			// Write lands only at the completing access edge
			if (psel && penable && pready && pwrite &&
					paddr == `CDAM_REG_CTRL) begin
				ctrl_q <= pwdata[2:0];
			end
		end
	end
endmodule : cdam_core

// file: design/cdam_defines.svh
// Offsets, opcodes, vectors, flag positions and cycle counts of the core
`ifndef CDAM_DEFINES_SVH
`define CDAM_DEFINES_SVH

// APB register byte offsets
`define CDAM_REG_CTRL 8'h00
`define CDAM_REG_STATUS 8'h04
`define CDAM_REG_ACC 8'h08
`define CDAM_REG_INDEX 8'h0c
`define CDAM_REG_PTRS 8'h10

// Control register fields
`define CDAM_CTRL_RUN 0
`define CDAM_CTRL_SOFT_MASKABLE 1
`define CDAM_CTRL_SOFT_PIN 2
`define CDAM_CTRL_RESET 3'h0

// Flag register bit positions
`define CDAM_FLAG_S 7
`define CDAM_FLAG_X 6
`define CDAM_FLAG_H 5
`define CDAM_FLAG_I 4
`define CDAM_FLAG_N 3
`define CDAM_FLAG_Z 2
`define CDAM_FLAG_V 1
`define CDAM_FLAG_C 0
`define CDAM_FLAGS_RESET 8'hd0

// Reset and interrupt vectors, stack start
`define CDAM_VEC_RESET 16'hfffe
`define CDAM_VEC_PIN 16'hfff4
`define CDAM_VEC_MASKABLE 16'hfff2
`define CDAM_SP_RESET 16'h00ff

// Prebytes and inherent opcodes
`define CDAM_PRE_PAGE1 8'h18
`define CDAM_PRE_PAGE2 8'h1a
`define CDAM_PRE_PAGE3 8'hcd
`define CDAM_OP_ADD_ACCS 8'h1b
`define CDAM_OP_ADD_ACC_IDX 8'h3a
`define CDAM_OP_ACC_TO_FLAGS 8'h06
`define CDAM_OP_NOP 8'h01
`define CDAM_OP_INT_RETURN 8'h3b
`define CDAM_OP_HALT 8'hcf
`define CDAM_COL_ADD_CARRY 4'h9
`define CDAM_COL_ADD_MEM 4'hb

// Base cycle counts, one more when a prebyte leads
`define CDAM_CYC_IMM 4'd2
`define CDAM_CYC_DIR 4'd3
`define CDAM_CYC_EXT 4'd4
`define CDAM_CYC_IND 4'd4
`define CDAM_CYC_REL 4'd3
`define CDAM_CYC_INH 4'd2
`define CDAM_CYC_ADD_IDX 4'd3

// Stack frame length in bytes
`define CDAM_STACK_BYTES 4'd9

`endif

// file: design/cdam_pkg.sv
// Types shared by the decode and addressing core
package cdam_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_VEC0, ST_VHI, ST_VLO, ST_OPC, ST_OPD,
		ST_WAIT, ST_LAST, ST_PUSH, ST_PULL, ST_STOP
	} cdam_state_t;
	typedef enum logic [2:0] {
		MD_INH, MD_IMM, MD_DIR, MD_EXT, MD_IND, MD_REL
	} cdam_mode_t;
	typedef enum logic [3:0] {
		OP_NOP, OP_ADD_ACCS, OP_ADD_IDX, OP_ADC, OP_ADD, OP_TAP,
		OP_BR, OP_INT_RET, OP_STOP
	} cdam_op_t;
endpackage : cdam_pkg

// file: design/cdam_alu8.sv
// Eight-bit adder with carry-in and the five arithmetic flags
`timescale 1ns/100ps
module cdam_alu8 (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	output logic [7:0] sum,
	output logic half,
	output logic neg,
	output logic zero,
	output logic ovf,
	output logic carry
);
	logic [4:0] low_sum; // Low nibble plus carry out of bit 3
	logic [8:0] full_sum; // Whole byte plus carry out of bit 7

	////////////////////////////////////////////////////////////////////////
	// Sum and flags
	always_comb begin
		low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full_sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		sum = full_sum[7:0];
		half = low_sum[4];
		neg = full_sum[7];
		zero = (full_sum[7:0] == 8'h00);
		// Signed overflow: like signs in, other sign out
		ovf = (a[7] == b[7]) && (full_sum[7] != a[7]);
		carry = full_sum[8];
	end
endmodule : cdam_alu8

// file: tb/cdam_mem.sv
// Asynchronous byte memory standing on the core's memory bus
`timescale 1ns/100ps
module cdam_mem (
	input wire logic pclk,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	// Full 64K space, so any byte address is legal
	logic [7:0] mem [0:65535];
	// no alignment
	// Unselected reads show the inverse so a stray sample is caught
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
	// Write lands at the edge ending the write cycle
	always @(posedge pclk) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
	end
endmodule : cdam_mem

// file: tb/cdam_core_chk.sv
// Port-level assertions for the decode and addressing core
`timescale 1ns/100ps
module cdam_core_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_rdata,
	input wire logic maskable_request,
	input wire logic stopped
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Named steps
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_vec;
		mem_rd && mem_addr inside {16'hfffe, 16'hfff4, 16'hfff2};
	endsequence
	sequence s_push;
		(mem_wr && mem_addr == $past(mem_addr) - 16'h1) [*8];
	endsequence
	////////////////////////////////////////////////////////////////
	// Register bus handshake
	property p_ready;
		s_setup |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready late");
	property p_ready_one;
		pready |=> !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("pready held");
	property p_ready_acc;
		pready |-> psel && penable;
	endproperty
	a_ready_acc: assert property (p_ready_acc) else $error("stray pready");
	property p_err_zero;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("bad error read");
	////////////////////////////////////////////////////////////////
	// Memory bus order
	property p_vec;
		s_vec |=> mem_rd && mem_addr == $past(mem_addr) + 16'h1;
	endproperty
	a_vec: assert property (p_vec) else $error("vector order");
	property p_push;
		$rose(mem_wr) |=> s_push ##1 !mem_wr ##[0:3] s_vec;
	endproperty
	a_push: assert property (p_push) else $error("stack frame");
	property p_direct;
		mem_rd && mem_rdata == 8'h99 && mem_addr[15:12] == 4'h1 |=>
			mem_addr == $past(mem_addr) + 16'h1 ##1
			mem_rd && mem_addr == {8'h00, $past(mem_rdata)};
	endproperty
	a_direct: assert property (p_direct) else $error("direct addr");
	property p_ext;
		mem_rd && mem_rdata == 8'hb9 && mem_addr[15:12] == 4'h1 |=> ##2
			mem_rd && mem_addr == {$past(mem_rdata, 2), $past(mem_rdata)};
	endproperty
	a_ext: assert property (p_ext) else $error("extended addr");
	// A maskable request wakes a stop, masked or not
	property p_stop_wake;
		stopped && maskable_request |-> ##[1:4] !stopped;
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("no wake");
endmodule : cdam_core_chk
bind cdam_core cdam_core_chk chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .mem_rdata(mem_rdata),
	.maskable_request(maskable_request), .stopped(stopped));

// file: tb/testbench.sv
// Self-checking bench: program in memory, checks through APB and on the stacked bytes in memory
`timescale 1ns/100ps
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr, mem_wdata, mem_rdata, a, b, f, t, bi, ii, dd, ll, o1, o2;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] mem_addr, x, y;
	logic mem_rd, mem_wr, maskable_request, nonmaskable_pin_request, stopped;
	logic [7:0] prog [$];
	logic [7:0] stk [9];
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	cdam_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.maskable_request(maskable_request),
		.nonmaskable_pin_request(nonmaskable_pin_request), .stopped(stopped));
	cdam_mem mem_u (.pclk(pclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////
	// Verdict and comparisons
	task summarize();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	task chk_word(input logic [31:0] g, input logic [31:0] w);
		samples_checked++;
		if (g !== w) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, g, w);
		end
	endtask : chk_word
	task chk_bit(input logic g, input logic w);
		chk_word({31'h0, g}, {31'h0, w});
	endtask : chk_bit
	// Adds as the core does, updating the five arithmetic flags
	function automatic void do_add(inout logic [7:0] d, input logic [7:0] m,
		input logic ci);
		logic [8:0] s;
		s = d + m + ci;
		f[5] = (d[3:0] + m[3:0] + ci) > 5'hf;
		f[3] = s[7];
		f[2] = s[7:0] == 8'h00;
		f[1] = (d[7] == m[7]) && (s[7] != d[7]);
		f[0] = s[8];
		d = s[7:0];
	endfunction : do_add
	////////////////////////////////////////////////////////////////
	// APB master: holds the request until pready is sampled
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, ad, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout bounds this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb
	task rdc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] w);
		apb(1'b0, ad, 32'h0);
		chk_word(r & m, w);
	endtask : rdc
	// Waits, bounded, for the core to halt
	task hold_stop();
		int n;
		n = 0;
		while (stopped !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		chk_bit(stopped, 1'b1);
	endtask : hold_stop
	// Wakes by a request; the pin one is held until stacking starts
	task step(input logic pin);
		int n;
		@(posedge pclk);
		{nonmaskable_pin_request, maskable_request} <= {pin, !pin};
		n = 0;
		while ((pin ? mem_wr !== 1'b1 : stopped === 1'b1) && n < 200) begin
			@(posedge pclk);
			n++;
		end
		{nonmaskable_pin_request, maskable_request} <= 2'h0;
		@(posedge pclk);
		hold_stop();
	endtask : step
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite} = 5'h0;
		{paddr, pwdata} = 40'h0;
		{maskable_request, nonmaskable_pin_request} = 2'h0;
		void'($urandom(32'h4dd2b86a));
		// Operands kept below 8'h80 so no program byte mimics an opcode
		t = ($urandom() & 8'h2f) | 8'h10;
		bi = $urandom() & 8'h7f;
		ii = $urandom() & 8'h7f;
		dd = $urandom() & 8'h7f;
		ll = $urandom() & 8'h7f;
		o1 = $urandom() & 8'h7f;
		o2 = $urandom() & 8'h7f;
		for (int i = 0; i < 65536; i++) begin
			mem_u.mem[i] = (i < 512 || i[15:8] == 8'h30) ? 8'($urandom()) : 8'h01;
		end
		// Halt first runs as a no-op while stop is still disabled
		prog = {8'hcf, 8'h8b, t, 8'h06, 8'hcf, 8'hcb, bi, 8'h1b, 8'hcf,
			8'h3a, 8'h18, 8'h3a, 8'hcf, 8'hc9, ii, 8'h99, dd, 8'hb9, 8'h30,
			ll, 8'ha9, o1, 8'h18, 8'ha9, o2, 8'hcf, 8'h01, 8'hcf};
		foreach (prog[k]) begin
			mem_u.mem[16'h1000 + k] = prog[k];
		end
		{mem_u.mem[16'hfffe], mem_u.mem[16'hffff]} = 16'h1000;
		{mem_u.mem[16'hfff4], mem_u.mem[16'hfff5]} = 16'h2000;
		// Pin service: a taken branch hops a stray return byte, then halts
		{mem_u.mem[16'h2000], mem_u.mem[16'h2001]} = 16'h2001;
		{mem_u.mem[16'h2002], mem_u.mem[16'h2003]} = 16'h3bcf;
		mem_u.mem[16'h2004] = 8'h3b;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdc(8'h04, 32'h3ff, 32'h0d0);
		apb(1'b1, 8'h04, 32'h0);
		rdc(8'h04, 32'hff, 32'hd0);
		rdc(8'h14, 32'hffffffff, 32'h0);
		chk_bit(e, 1'b1);
		apb(1'b1, 8'h00, 32'h1);
		hold_stop();
		rdc(8'h08, 32'hffffffff, {16'h0, t, 8'h0});
		rdc(8'h04, 32'hff, t);
		{a, b, f, x, y} = {t, 8'h0, t, 32'h0};
		do_add(b, bi, 1'b0);
		do_add(a, b, 1'b0);
		step(1'b0);
		rdc(8'h08, 32'hffff, {a, b});
		rdc(8'h04, 32'hff, f);
		x = {8'h0, b};
		y = x;
		step(1'b0);
		rdc(8'h0c, 32'hffffffff, {y, x});
		rdc(8'h04, 32'hff, f);
		do_add(b, ii, f[0]);
		do_add(a, mem_u.mem[{8'h0, dd}], f[0]);
		do_add(a, mem_u.mem[{8'h30, ll}], f[0]);
		do_add(a, mem_u.mem[x + o1], f[0]);
		do_add(a, mem_u.mem[y + o2], f[0]);
		step(1'b0);
		rdc(8'h08, 32'hffff, {a, b});
		rdc(8'h04, 32'hff, f);
		stk = '{f, b, a, x[15:8], x[7:0], y[15:8], y[7:0], 8'h10, 8'h1b};
		step(1'b1);
		for (int i = 0; i < 9; i++) begin
			chk_word(mem_u.mem[16'h00f7 + i], stk[i]);
		end
		rdc(8'h04, 32'hff, f | 8'h50);
		step(1'b0);
		rdc(8'h04, 32'hff, f);
		rdc(8'h10, 32'hffffffff, 32'h00ff101c);
		summarize();
	end
endmodule : testbench
